/* File: sba_params.svh */
// Purpose: constants of the system bus arbiter
// Assumes: included by the arbiter and its round-robin picker
// Notes: the arbitration control bits sit on plain ports, no software bus
`ifndef SBA_PARAMS_SVH
`define SBA_PARAMS_SVH

`define SBA_MASTERS        8
`define SBA_RING           7
`define SBA_IDX_EXT        3'h0
`define SBA_IDX_CORE       3'h7
`define SBA_CTRL_MODE_BIT  0
`define SBA_CTRL_BOOST_EN  1
`define SBA_CTRL_BOOST_ACT 2
`define SBA_CTRL_RESET     3'h0
`define SBA_PTR_RESET      3'h0

`endif

/* File: sba_pkg.sv */
// Purpose: types of the system bus arbiter
// Assumes: nothing beyond the params header
// Notes: master index 0 is the external master, 7 the processor core
package sba_pkg;

	typedef enum logic
	{
		SBA_IDLE,
		SBA_OWNED
	} sba_state_type;

	// control inputs, standing in for the arbitration control register
	typedef struct packed
	{
		logic priority_mode_select;
		logic core_boost_enable;
		logic boost_write;
		logic boost_wdata;
	} sba_ctrl_type;

	typedef struct packed
	{
		logic [2:0] arbitration_control;
		logic       bus_busy;
		logic [2:0] owner;
	} sba_status_type;

endpackage

/* File: sba_rr_pick.sv */
// Purpose: round-robin picker over a ring of requesters
// Assumes: pointer below N
// Notes: combinational; the first request at or after the pointer wins
`timescale 1ns/10ps
`include "sba_params.svh"
module sba_rr_pick
	import sba_pkg::*;
#(
	parameter int N = `SBA_RING,
	parameter int W = $clog2(N)
)
(
	// ring
	input  wire logic [N-1:0] i_request,
	input  wire logic [W-1:0] i_pointer,
	// choice
	output logic              o_valid,
	output logic [W-1:0]      o_index
);

	// scan from the far end so the nearest request to the pointer is kept last
	always_comb
	begin
		int idx;
		idx     = 0;
		o_valid = 1'b0;
		o_index = '0;
		for (int k = N - 1; k >= 0; k--)
		begin
			idx = (int'(i_pointer) + k) % N;
			if (i_request[idx])
			begin
				o_valid = 1'b1;
				o_index = W'(idx);
			end
		end
	end

endmodule

/* File: sba_arbiter.sv */
// Purpose: system bus arbiter for eight masters, fixed or rotating priority
// Assumes: request bits 7..1 come from on-chip logic on i_clock; bit 0 is the external pin
// Notes: grant is registered; a release costs one idle cycle before the next grant
`timescale 1ns/10ps
`include "sba_params.svh"
module sba_arbiter
	import sba_pkg::*;
#(
	parameter int MASTERS = `SBA_MASTERS
)
(
	// clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_reset_n,
	// masters
	input  wire logic [MASTERS-1:0] i_request,
	output logic      [MASTERS-1:0] o_grant,
	// control and core interrupt
	input  wire sba_ctrl_type       i_ctrl,
	input  wire logic               i_core_irq_unmasked,
	// state
	output sba_status_type          o_status
);

	sba_state_type      state_q;
	logic [MASTERS-1:0] grant_q;
	logic [2:0]         owner_q;
	logic [2:0]         ptr_q;
	logic               boost_active_q;
	logic               ext_meta_q;
	logic               ext_sync_q;
	logic [MASTERS-1:0] req_s;
	logic               boost_set;
	logic               boost_on;
	logic               rotating;
	logic [2:0]         fixed_pick;
	logic               rr_valid;
	logic [2:0]         rr_index;
	logic [2:0]         winner_d;
	logic               any_req;
	logic               owner_req;

	// the external request is asynchronous, so it is synchronised first
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
		end
		else
		begin
			ext_meta_q <= i_request[0];
			ext_sync_q <= ext_meta_q;
		end
	end

	assign req_s     = {i_request[MASTERS-1:1], ext_sync_q};
	assign any_req   = |req_s;
	assign owner_req = req_s[owner_q];
	assign rotating  = i_ctrl.priority_mode_select;

	// boost counts only in fixed mode with enable set
	assign boost_on  = !rotating && i_ctrl.core_boost_enable && boost_active_q;

	// lowest index wins; under boost the core is tried right after the external master
	function automatic logic [2:0] fixed_choice(input logic [MASTERS-1:0] req, input logic boost);
		logic [2:0] pick;
		pick = `SBA_IDX_CORE;
		for (int i = MASTERS - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				pick = 3'(i);
			end
		end
		if (boost && req[`SBA_IDX_CORE] && !req[`SBA_IDX_EXT])
		begin
			pick = `SBA_IDX_CORE;
		end
		return pick;
	endfunction

	assign fixed_pick = fixed_choice(req_s, boost_on);

	sba_rr_pick #(
		.N (`SBA_RING),
		.W (3)
	) u_rr_pick (
		.i_request (req_s[MASTERS-1:1]),
		.i_pointer (ptr_q),
		.o_valid   (rr_valid),
		.o_index   (rr_index)
	);

	always_comb
	begin
		if (!rotating)
		begin
			winner_d = fixed_pick;
		end
		else if (req_s[`SBA_IDX_EXT])
		begin
			winner_d = `SBA_IDX_EXT;
		end
		else
		begin
			winner_d = rr_valid ? 3'(rr_index + 3'h1) : `SBA_IDX_CORE;
		end
	end

	// ownership: one holder at a time, released by dropping its request
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q <= SBA_IDLE;
			grant_q <= '0;
			owner_q <= `SBA_IDX_EXT;
		end
		else
		begin
			unique case (state_q)
				SBA_IDLE:
				begin
					if (any_req)
					begin
						state_q           <= SBA_OWNED;
						grant_q           <= '0;
						grant_q[winner_d] <= 1'b1;
						owner_q           <= winner_d;
					end
				end
				SBA_OWNED:
				begin
					if (!owner_req)
					begin
						state_q <= SBA_IDLE;
						grant_q <= '0;
					end
				end
			endcase
		end
	end

	// rotating pointer moves just past each ring master it grants
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ptr_q <= `SBA_PTR_RESET;
		end
		else if (state_q == SBA_IDLE && any_req && rotating && winner_d != `SBA_IDX_EXT)
		begin
			ptr_q <= (winner_d == `SBA_IDX_CORE) ? 3'h0 : winner_d;
		end
	end

	// boost-active flag: set beats a clear in the same cycle
	assign boost_set = !rotating && i_ctrl.core_boost_enable && i_core_irq_unmasked;

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			boost_active_q <= 1'b0;
		end
		else if (boost_set)
		begin
			boost_active_q <= 1'b1;
		end
		else if (i_ctrl.boost_write && !i_ctrl.boost_wdata)
		begin
			boost_active_q <= 1'b0;
		end
	end

	// status shown from flops plus the live control levels
	always_comb
	begin
		o_status                                        = '0;
		o_status.arbitration_control[`SBA_CTRL_MODE_BIT]  = i_ctrl.priority_mode_select;
		o_status.arbitration_control[`SBA_CTRL_BOOST_EN]  = i_ctrl.core_boost_enable;
		o_status.arbitration_control[`SBA_CTRL_BOOST_ACT] = boost_active_q;
		o_status.bus_busy                               = (state_q == SBA_OWNED);
		o_status.owner                                  = owner_q;
	end

	assign o_grant = grant_q;

	// checks
	sequence s_pick_cycle;
		state_q == SBA_IDLE && any_req;
	endsequence

	sequence s_release;
		state_q == SBA_OWNED && !owner_req;
	endsequence

	property p_one_owner;
		@(posedge i_clock) disable iff (!i_reset_n)
		$onehot0(grant_q) && (state_q == SBA_OWNED) == (grant_q != '0);
	endproperty
	a_one_owner: assert property (p_one_owner) else $error("grant not one-hot or out of step");

	property p_hold;
		@(posedge i_clock) disable iff (!i_reset_n)
		state_q == SBA_OWNED && owner_req |=> $stable(grant_q) && grant_q != '0;
	endproperty
	a_hold: assert property (p_hold) else $error("grant moved while owner still requests");

	property p_release;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_release |=> grant_q == '0 ##1 (!$past(any_req) || grant_q != '0);
	endproperty
	a_release: assert property (p_release) else $error("release did not free or re-arbitrate");

	property p_fixed_plain;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_pick_cycle and (!rotating && !boost_on) |=> grant_q == ($past(req_s) & (~$past(req_s) + 8'h01));
	endproperty
	a_fixed_plain: assert property (p_fixed_plain) else $error("fixed pick is not the highest priority");

	property p_fixed_boost;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_pick_cycle and (boost_on && req_s[7] && !req_s[0]) |=> grant_q[7];
	endproperty
	a_fixed_boost: assert property (p_fixed_boost) else $error("boosted core not second");

	property p_no_boost;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_pick_cycle and (!rotating && !i_ctrl.core_boost_enable && !req_s[0] && req_s[1]) |=> !grant_q[7] && grant_q[1];
	endproperty
	a_no_boost: assert property (p_no_boost) else $error("core left lowest without boost enable");

	property p_flag_set;
		@(posedge i_clock) disable iff (!i_reset_n)
		boost_set |=> boost_active_q ##0 o_status.arbitration_control[2];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("boost-active not set by interrupt");

	property p_flag_write;
		@(posedge i_clock) disable iff (!i_reset_n)
		i_ctrl.boost_write && !boost_set |=> boost_active_q == ($past(boost_active_q) && $past(i_ctrl.boost_wdata));
	endproperty
	a_flag_write: assert property (p_flag_write) else $error("boost-active write misbehaved");

	property p_rot_ext;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_pick_cycle and (rotating && req_s[0]) |=> grant_q[0] && $stable(ptr_q);
	endproperty
	a_rot_ext: assert property (p_rot_ext) else $error("external master lost in rotating mode");

	property p_rot_turn;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_pick_cycle and (rotating && !req_s[0] && req_s[ptr_q + 3'h1]) |=> grant_q[$past(ptr_q) + 3'h1];
	endproperty
	a_rot_turn: assert property (p_rot_turn) else $error("round robin skipped the pointed master");

	property p_ptr_move;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_pick_cycle and (rotating && !req_s[0]) |=> ptr_q == (owner_q == 3'h7 ? 3'h0 : owner_q);
	endproperty
	a_ptr_move: assert property (p_ptr_move) else $error("pointer not past last grant");

	property p_rot_flag;
		@(posedge i_clock) disable iff (!i_reset_n)
		rotating && !boost_active_q |=> !boost_active_q;
	endproperty
	a_rot_flag: assert property (p_rot_flag) else $error("boost flag set in rotating mode");

	property p_owner_grant;
		@(posedge i_clock) disable iff (!i_reset_n)
		state_q == SBA_OWNED |-> grant_q[owner_q];
	endproperty
	a_owner_grant: assert property (p_owner_grant) else $error("grant does not match the recorded owner");

	property p_fixed_ext;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_pick_cycle and (!rotating && req_s[0]) |=> grant_q[0];
	endproperty
	a_fixed_ext: assert property (p_fixed_ext) else $error("external master lost in fixed mode");

	property p_ptr_hold;
		@(posedge i_clock) disable iff (!i_reset_n)
		!(state_q == SBA_IDLE && any_req && rotating) |=> $stable(ptr_q);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without a rotating grant");

	property p_flag_sticky;
		@(posedge i_clock) disable iff (!i_reset_n)
		boost_active_q && !(i_ctrl.boost_write && !i_ctrl.boost_wdata) |=> boost_active_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("boost-active dropped without a clear");

	property p_flag_quiet;
		@(posedge i_clock) disable iff (!i_reset_n)
		!boost_active_q && !boost_set |=> !boost_active_q;
	endproperty
	a_flag_quiet: assert property (p_flag_quiet) else $error("boost-active set without an interrupt");

	property p_release_idle;
		@(posedge i_clock) disable iff (!i_reset_n)
		s_release |=> state_q == SBA_IDLE && !o_status.bus_busy;
	endproperty
	a_release_idle: assert property (p_release_idle) else $error("bus still busy after release");

endmodule

/* File: sba_master_model.sv */
// Purpose: behavioural masters on the request side of the arbiter
// Assumes: at most one grant at a time
// Notes: a master drops its request HOLD cycles into its grant
`timescale 1ns/10ps
module sba_master_model
#(
	parameter int HOLD = 3
)
(
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	// commands from the bench
	input  wire logic [7:0] i_start,
	input  wire logic [7:0] i_withdraw,
	// arbiter side
	input  wire logic [7:0] i_grant,
	output logic      [7:0] o_request
);
	logic [7:0] cnt_q;

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			cnt_q <= 8'h00;
		else
			cnt_q <= (|(i_grant & o_request)) ? cnt_q + 8'h01 : 8'h00;
	end

	// a withdrawal only lands before the grant, so an owner always releases on its own
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_request <= 8'h00;
		else
			o_request <= (o_request | i_start) & ~(i_withdraw & ~i_grant)
				& ~((cnt_q == 8'(HOLD - 1)) ? i_grant : 8'h00);
	end
endmodule

/* File: test_system_bus_arbiter.sv */
// Purpose: self-checking bench of the system bus arbiter
// Assumes: masters modelled by sba_master_model with a hold of 3
// Notes: grant order is logged at each new grant and compared per scenario
`timescale 1ns/10ps
module test_system_bus_arbiter
	import sba_pkg::*;
;
	logic           i_clock;
	logic           i_reset_n;
	logic [7:0]     request;
	logic [7:0]     grant;
	logic [7:0]     start;
	logic [7:0]     withdraw;
	logic [7:0]     prev;
	logic           irq;
	sba_ctrl_type   ctrl;
	sba_status_type status;
	int             err_total;
	int             cmp_count;
	logic [2:0]     seen[$];

	sba_arbiter #(.MASTERS(8)) dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_request(request),
		.o_grant(grant), .i_ctrl(ctrl), .i_core_irq_unmasked(irq), .o_status(status));
	sba_master_model #(.HOLD(3)) model_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_start(start),
		.i_withdraw(withdraw), .i_grant(grant), .o_request(request));

	initial
	begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// log each fresh grant; every grant follows an idle cycle
	always @(posedge i_clock)
	begin
		prev <= grant;
		if (grant !== 8'h00 && prev === 8'h00)
			for (int m = 0; m < 8; m++)
				if (grant[m])
					seen.push_back(3'(m));
	end

	always @(negedge i_clock)
		if (i_reset_n)
			chk("grant_onehot", 8'h01, 8'($onehot0(grant)));

	// exp holds one index per nibble, first grant in the top nibble of n
	task automatic run_seq(input logic [7:0] st, input logic [7:0] wd, input logic [31:0] exp, input int n);
		seen.delete();
		@(posedge i_clock) start <= st;
		@(posedge i_clock) start <= 8'h00;
		for (int i = 0; i < 20 && grant === 8'h00; i++)
			@(negedge i_clock);
		chk("bus_busy", 8'h01, {7'h00, status.bus_busy});
		chk("owner", {5'h00, exp[4*(n-1) +: 3]}, {5'h00, status.owner});
		@(posedge i_clock) withdraw <= wd;
		@(posedge i_clock) withdraw <= 8'h00;
		for (int i = 0; i < 300 && !(seen.size() >= n && grant === 8'h00); i++)
			@(negedge i_clock);
		repeat (12) @(negedge i_clock);
		chk("grant_idle", 8'h00, grant);
		chk("bus_free", 8'h00, {7'h00, status.bus_busy});
		chk("grant_count", 8'(n), 8'(seen.size()));
		for (int i = 0; i < n && i < seen.size(); i++)
			chk("grant_order", {5'h00, exp[4*(n-1-i) +: 3]}, {5'h00, seen[i]});
	endtask

	task automatic boost(input logic en, input logic md, input logic ir, input logic wr, input logic wd,
		input logic exp);
		@(posedge i_clock)
		begin
			ctrl <= '{md, en, wr, wd};
			irq <= ir;
		end
		@(posedge i_clock)
		begin
			ctrl.boost_write <= 1'b0;
			irq <= 1'b0;
		end
		@(negedge i_clock) chk("arbitration_control", {5'h00, exp, en, md}, {5'h00, status.arbitration_control});
	endtask

	initial
	begin
		i_reset_n = 1'b0;
		start = 8'h00;
		withdraw = 8'h00;
		irq = 1'b0;
		ctrl = '0;
		err_total = 0;
		cmp_count = 0;
		repeat (5) @(posedge i_clock);
		i_reset_n <= 1'b1;
		@(negedge i_clock);
		chk("grant_reset", 8'h00, grant);
		chk("status_reset", 8'h00, {1'b0, status});
		run_seq(8'hFF, 8'h00, 32'h10234567, 8);
		boost(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		boost(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		run_seq(8'hFE, 8'h00, 32'h1234567, 7);
		boost(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		run_seq(8'hFE, 8'h00, 32'h7123456, 7);
		boost(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
		boost(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		boost(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		run_seq(8'h08, 8'h00, 32'h3, 1);
		run_seq(8'h27, 8'h00, 32'h5012, 4);
		run_seq(8'h48, 8'h40, 32'h3, 1);
		run_seq(8'h10, 8'h00, 32'h4, 1);
		report_and_stop();
	end

	// the scenarios need well under 1500 cycles
	initial
	begin
		repeat (4000) @(posedge i_clock);
		$display("[FAIL] watchdog expected end seen hang");
		err_total++;
		report_and_stop();
	end
endmodule
